// ---- hw/rsx_pkg.sv ----
// Package of constants and types for the return/rotate/subtract/swap executor
package rsx_pkg;
	localparam int unsigned CLK_HZ = 100000000;
	localparam logic [13:0] OP_RET_IRQ = 14'h0009;
	localparam logic [13:0] OP_RET_SUB = 14'h0008;
	localparam logic [13:0] OP_LOAD_OPT = 14'h0062;
	localparam logic [13:0] OP_SLEEP = 14'h0063;
	localparam logic [5:0] OP_RLF = 6'h0D;
	localparam logic [5:0] OP_SUBF = 6'h02;
	localparam logic [5:0] OP_SWAP = 6'h0E;
	localparam logic [3:0] OP_RETLIT = 4'hD;
	localparam logic [4:0] OP_SUBLIT = 5'h1E;
	localparam int GIE_BIT = 7;
	localparam logic [7:0] WDT_CLEAR = 8'h00;
	localparam logic [31:0] ADDR_INSTR = 32'h0000_0000;
	localparam logic [31:0] ADDR_ACC = 32'h0000_0004;
	localparam logic [31:0] ADDR_FREG = 32'h0000_0008;
	localparam logic [31:0] ADDR_STACK = 32'h0000_000C;
	localparam logic [31:0] ADDR_STATUS = 32'h0000_0010;
	localparam logic [31:0] ADDR_OPTION = 32'h0000_0014;
	localparam logic [31:0] ADDR_PC = 32'h0000_0018;
	localparam logic [31:0] ADDR_IRQCTL = 32'h0000_001C;
	localparam logic [31:0] ADDR_CTRL = 32'h0000_0020;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	localparam int ST_C = 0;
	localparam int ST_DC = 1;
	localparam int ST_Z = 2;
	localparam int ST_PD = 3;
	localparam int ST_TO = 4;
	localparam int ST_SLEEP = 5;
	localparam int ST_BUSY = 6;
	typedef enum logic [1:0] {
		RSX_Q1 = 2'b00,
		RSX_Q2 = 2'b01,
		RSX_Q3 = 2'b11,
		RSX_Q4 = 2'b10
	} rsx_phase_e;
	typedef struct packed {
		logic ret_irq;
		logic ret_sub;
		logic ret_lit;
		logic load_opt;
		logic sleep;
		logic rotate_left_instr;
		logic subf;
		logic sublit;
		logic swap;
	} rsx_dec_s;
	typedef struct packed {
		logic [7:0] value;
		logic c;
		logic dc;
		logic z;
	} rsx_alu_s;
endpackage

// ---- hw/rsx_alu.sv ----
// Datapath for rotate, subtract and swap
`timescale 1ns/1ns
`default_nettype none
module rsx_alu #(
	parameter int WIDTH = 8
) (
	input wire logic [WIDTH-1:0] opa,
	input wire logic [WIDTH-1:0] acc,
	input wire logic carry_in,
	input wire logic sel_rot,
	input wire logic sel_sub,
	output rsx_pkg::rsx_alu_s res
);
	initial begin
		if (WIDTH != 8) $error("rsx_alu supports WIDTH 8 only");
	end
	logic [WIDTH:0] diff;
	logic [4:0] low_diff;
	always_comb begin
		diff = {1'b0, opa} - {1'b0, acc};
		low_diff = {1'b0, opa[3:0]} - {1'b0, acc[3:0]};
		res.c = carry_in;
		res.dc = 1'b0;
		res.z = 1'b0;
		if (sel_rot) begin
			res.value = {opa[WIDTH-2:0], carry_in};
			res.c = opa[WIDTH-1];
		end else if (sel_sub) begin
			res.value = diff[WIDTH-1:0];
			res.c = ~diff[WIDTH];
			res.dc = ~low_diff[4];
			res.z = (diff[WIDTH-1:0] == '0);
		end else begin
			res.value = {opa[3:0], opa[7:4]};
		end
	end
endmodule
`default_nettype wire

// ---- hw/rsx_exec.sv ----
// Executor for returns, option load, rotate, sleep, subtract and swap
`timescale 1ns/1ns
`default_nettype none
module rsx_exec (
	input wire logic clock,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic sleep_mode,
	output logic osc_stop,
	output logic watchdog_clear
);
	logic [13:0] instr_reg;
	logic [7:0] acc_reg;
	logic [7:0] freg_reg;
	logic [12:0] stack_top_reg;
	logic [12:0] pc_reg;
	logic [7:0] option_reg;
	logic [7:0] irq_control_reg;
	logic [7:0] watchdog_counter_reg;
	logic c_reg, dc_reg, z_reg;
	logic watchdog_expiry_flag_reg, powerdown_flag_reg;
	logic sleep_reg;
	logic busy_reg;
	logic second_reg;
	rsx_pkg::rsx_phase_e phase_reg;
	rsx_pkg::rsx_dec_s dec;
	rsx_pkg::rsx_alu_s alu;
	logic aw_held, w_held;
	logic [31:0] awaddr_reg, wdata_reg;
	logic wr_go, go_write;
	logic is_two;

	always_comb begin
		dec.ret_irq = (instr_reg == rsx_pkg::OP_RET_IRQ);
		dec.ret_sub = (instr_reg == rsx_pkg::OP_RET_SUB);
		dec.ret_lit = (instr_reg[13:10] == rsx_pkg::OP_RETLIT);
		dec.load_opt = (instr_reg == rsx_pkg::OP_LOAD_OPT);
		dec.sleep = (instr_reg == rsx_pkg::OP_SLEEP);
		dec.rotate_left_instr = (instr_reg[13:8] == rsx_pkg::OP_RLF);
		dec.subf = (instr_reg[13:8] == rsx_pkg::OP_SUBF);
		dec.sublit = (instr_reg[13:9] == rsx_pkg::OP_SUBLIT);
		dec.swap = (instr_reg[13:8] == rsx_pkg::OP_SWAP);
	end
	assign is_two = dec.ret_irq | dec.ret_sub | dec.ret_lit;

	rsx_alu #(.WIDTH(8)) u_alu (
		.opa(dec.sublit ? instr_reg[7:0] : freg_reg),
		.acc(acc_reg),
		.carry_in(c_reg),
		.sel_rot(dec.rotate_left_instr),
		.sel_sub(dec.subf | dec.sublit),
		.res(alu)
	);

	// Bus write handshake
	assign s_axi_awready = clk_en && !aw_held && !s_axi_bvalid;
	assign s_axi_wready = clk_en && !w_held && !s_axi_bvalid;
	assign wr_go = (aw_held || s_axi_awvalid) && (w_held || s_axi_wvalid) && !s_axi_bvalid;
	assign go_write = clk_en && wr_go && !busy_reg;
	always_ff @(posedge clock) begin
		if (rst) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			awaddr_reg <= 32'h0000_0000;
			wdata_reg <= 32'h0000_0000;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= rsx_pkg::RESP_OKAY;
		end else if (clk_en) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				awaddr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				wdata_reg <= s_axi_wdata;
			end
			if (go_write) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (wa() > rsx_pkg::ADDR_CTRL) ? rsx_pkg::RESP_SLVERR
					: rsx_pkg::RESP_OKAY;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	function automatic logic [31:0] wa();
		wa = aw_held ? awaddr_reg : s_axi_awaddr;
	endfunction
	function automatic logic [31:0] wd();
		wd = w_held ? wdata_reg : s_axi_wdata;
	endfunction

	// Phase sequencer: Q1..Q4 each one clock
	always_ff @(posedge clock) begin
		if (rst) begin
			phase_reg <= rsx_pkg::RSX_Q1;
			busy_reg <= 1'b0;
			second_reg <= 1'b0;
		end else if (clk_en) begin
			if (go_write && wa() == rsx_pkg::ADDR_CTRL && wd()[0] && !sleep_reg) begin
				busy_reg <= 1'b1;
				phase_reg <= rsx_pkg::RSX_Q1;
				second_reg <= 1'b0;
			end else if (busy_reg) begin
				case (phase_reg)
					rsx_pkg::RSX_Q1: phase_reg <= rsx_pkg::RSX_Q2;
					rsx_pkg::RSX_Q2: phase_reg <= rsx_pkg::RSX_Q3;
					rsx_pkg::RSX_Q3: phase_reg <= rsx_pkg::RSX_Q4;
					default: begin
						phase_reg <= rsx_pkg::RSX_Q1;
						if (is_two && !second_reg) begin
							second_reg <= 1'b1;
						end else begin
							busy_reg <= 1'b0;
							second_reg <= 1'b0;
						end
					end
				endcase
			end
		end
	end

	logic q3_first, q4_first;
	assign q3_first = busy_reg && !second_reg && phase_reg == rsx_pkg::RSX_Q3;
	assign q4_first = busy_reg && !second_reg && phase_reg == rsx_pkg::RSX_Q4;

	// Instruction, accumulator, file register
	always_ff @(posedge clock) begin
		if (rst) begin
			instr_reg <= 14'h0000;
			acc_reg <= 8'h00;
			freg_reg <= 8'h00;
		end else if (clk_en) begin
			if (go_write && wa() == rsx_pkg::ADDR_INSTR) instr_reg <= wd()[13:0];
			if (go_write && wa() == rsx_pkg::ADDR_ACC) acc_reg <= wd()[7:0];
			if (go_write && wa() == rsx_pkg::ADDR_FREG) freg_reg <= wd()[7:0];
			if (q4_first) begin
				if (dec.ret_lit) acc_reg <= instr_reg[7:0];
				if (dec.sublit) acc_reg <= alu.value;
				if (dec.rotate_left_instr || dec.subf || dec.swap) begin
					if (instr_reg[7]) freg_reg <= alu.value;
					else acc_reg <= alu.value;
				end
			end
		end
	end

	// Stack, program counter, option, interrupt control
	always_ff @(posedge clock) begin
		if (rst) begin
			stack_top_reg <= 13'h0000;
			pc_reg <= 13'h0000;
			option_reg <= 8'hFF;
			irq_control_reg <= 8'h00;
		end else if (clk_en) begin
			if (go_write && wa() == rsx_pkg::ADDR_STACK) stack_top_reg <= wd()[12:0];
			if (go_write && wa() == rsx_pkg::ADDR_PC) pc_reg <= wd()[12:0];
			if (go_write && wa() == rsx_pkg::ADDR_OPTION) option_reg <= wd()[7:0];
			if (go_write && wa() == rsx_pkg::ADDR_IRQCTL) irq_control_reg <= wd()[7:0];
			if (q3_first && dec.ret_irq) irq_control_reg[rsx_pkg::GIE_BIT] <= 1'b1;
			if (q4_first && is_two) pc_reg <= stack_top_reg;
			if (q4_first && dec.load_opt) option_reg <= acc_reg;
		end
	end

	// Status flags, watchdog and sleep
	always_ff @(posedge clock) begin
		if (rst) begin
			c_reg <= 1'b0;
			dc_reg <= 1'b0;
			z_reg <= 1'b0;
			watchdog_expiry_flag_reg <= 1'b1;
			powerdown_flag_reg <= 1'b1;
			watchdog_counter_reg <= 8'h00;
			sleep_reg <= 1'b0;
			watchdog_clear <= 1'b0;
		end else if (clk_en) begin
			watchdog_clear <= 1'b0;
			if (go_write && wa() == rsx_pkg::ADDR_STATUS) begin
				c_reg <= wd()[rsx_pkg::ST_C];
				dc_reg <= wd()[rsx_pkg::ST_DC];
				z_reg <= wd()[rsx_pkg::ST_Z];
			end
			if (go_write && wa() == rsx_pkg::ADDR_CTRL && wd()[1]) sleep_reg <= 1'b0;
			if (!sleep_reg) watchdog_counter_reg <= watchdog_counter_reg + 8'h01;
			if (q4_first) begin
				if (dec.rotate_left_instr) c_reg <= alu.c;
				if (dec.subf || dec.sublit) begin
					c_reg <= alu.c;
					dc_reg <= alu.dc;
					z_reg <= alu.z;
				end
				if (dec.sleep) begin
					watchdog_counter_reg <= rsx_pkg::WDT_CLEAR;
					watchdog_clear <= 1'b1;
					watchdog_expiry_flag_reg <= 1'b1;
					powerdown_flag_reg <= 1'b0;
					sleep_reg <= 1'b1;
				end
			end
		end
	end
	assign sleep_mode = sleep_reg;
	assign osc_stop = sleep_reg;

	// Read channel
	assign s_axi_arready = clk_en && !s_axi_rvalid;
	always_ff @(posedge clock) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= rsx_pkg::RESP_OKAY;
		end else if (clk_en) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= rsx_pkg::RESP_OKAY;
				if (s_axi_araddr == rsx_pkg::ADDR_INSTR) s_axi_rdata <= {18'h0, instr_reg};
				else if (s_axi_araddr == rsx_pkg::ADDR_ACC) s_axi_rdata <= {24'h0, acc_reg};
				else if (s_axi_araddr == rsx_pkg::ADDR_FREG) s_axi_rdata <= {24'h0, freg_reg};
				else if (s_axi_araddr == rsx_pkg::ADDR_STACK) s_axi_rdata <= {19'h0, stack_top_reg};
				else if (s_axi_araddr == rsx_pkg::ADDR_STATUS) s_axi_rdata <= {25'h0, busy_reg,
					sleep_reg, watchdog_expiry_flag_reg, powerdown_flag_reg, z_reg, dc_reg, c_reg};
				else if (s_axi_araddr == rsx_pkg::ADDR_OPTION) s_axi_rdata <= {24'h0, option_reg};
				else if (s_axi_araddr == rsx_pkg::ADDR_PC) s_axi_rdata <= {19'h0, pc_reg};
				else if (s_axi_araddr == rsx_pkg::ADDR_IRQCTL) s_axi_rdata <= {24'h0, irq_control_reg};
				else if (s_axi_araddr == rsx_pkg::ADDR_CTRL) s_axi_rdata <= {24'h0, watchdog_counter_reg};
				else begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= rsx_pkg::RESP_SLVERR;
				end
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Checks
	property p_gie_q3;
		@(posedge clock) disable iff (rst)
		(clk_en && q3_first && dec.ret_irq) |=> irq_control_reg[rsx_pkg::GIE_BIT];
	endproperty
	a_gie_q3: assert property (p_gie_q3) else $error("gie not set in q3");
	property p_pop;
		@(posedge clock) disable iff (rst)
		(clk_en && q4_first && is_two) |=> pc_reg == $past(stack_top_reg);
	endproperty
	a_pop: assert property (p_pop) else $error("pop not done in q4");
	property p_two_cycle;
		@(posedge clock) disable iff (rst || !clk_en)
		(q4_first && is_two) |=> busy_reg && second_reg;
	endproperty
	a_two_cycle: assert property (p_two_cycle) else $error("second cycle missing");
	property p_opt;
		@(posedge clock) disable iff (rst)
		(clk_en && q4_first && dec.load_opt) |=> option_reg == $past(acc_reg) && $stable(c_reg);
	endproperty
	a_opt: assert property (p_opt) else $error("option load wrong");
	property p_sleep;
		@(posedge clock) disable iff (rst)
		(clk_en && q4_first && dec.sleep) |=> sleep_reg && !powerdown_flag_reg
			&& watchdog_expiry_flag_reg && watchdog_counter_reg == rsx_pkg::WDT_CLEAR;
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep effects wrong");
	property p_sub_carry;
		@(posedge clock) disable iff (rst)
		(clk_en && q4_first && dec.subf) |=> c_reg == ($past(freg_reg) >= $past(acc_reg));
	endproperty
	a_sub_carry: assert property (p_sub_carry) else $error("sub carry wrong");
	property p_swap_flags;
		@(posedge clock) disable iff (rst)
		(clk_en && q4_first && dec.swap) |=> $stable(c_reg) && $stable(z_reg) && $stable(dc_reg);
	endproperty
	a_swap_flags: assert property (p_swap_flags) else $error("swap changed flags");
	property p_rlf;
		@(posedge clock) disable iff (rst)
		(clk_en && q4_first && dec.rotate_left_instr && !instr_reg[7]) |=>
			acc_reg == {$past(freg_reg[6:0]), $past(c_reg)} && c_reg == $past(freg_reg[7]);
	endproperty
	a_rlf: assert property (p_rlf) else $error("rotate wrong");
endmodule
`default_nettype wire

// ---- tb/rsx_prog_model.sv ----
// Program memory and return stack model for the executor bench
`timescale 1ns/1ns
`default_nettype none
module rsx_prog_model;
	// Program words, one per test step
	function automatic logic [13:0] word_at(input int i);
		case (i)
			0: return {rsx_pkg::OP_SUBLIT, 9'h002};
			1: return {rsx_pkg::OP_SUBF, 8'h80};
			2: return {rsx_pkg::OP_RLF, 8'h00};
			3: return {rsx_pkg::OP_SWAP, 8'h00};
			4: return rsx_pkg::OP_RET_IRQ;
			5: return {rsx_pkg::OP_RETLIT, 10'h0AB};
			6: return rsx_pkg::OP_RET_SUB;
			7: return rsx_pkg::OP_LOAD_OPT;
			8: return rsx_pkg::OP_SLEEP;
			9: return {rsx_pkg::OP_RLF, 8'h85};
			default: return 14'h0000;
		endcase
	endfunction
	// Return address held at the stack top
	function automatic logic [12:0] ret_at(input int i);
		return 13'h0100 + 13'(i);
	endfunction
endmodule
`default_nettype wire

// ---- tb/return_rotate_subtract_swap_exec_tb.sv ----
// Self-checking bench for the return/rotate/subtract/swap executor
`timescale 1ns/1ns
`default_nettype none
module return_rotate_subtract_swap_exec_tb;
	logic clock, rst, clk_en;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, v;
	logic [3:0] s_axi_wstrb;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic sleep_mode, osc_stop, watchdog_clear;
	int fails, comparisons, cyc, wclr;
	rsx_exec u_rsx_exec (.clock, .rst, .clk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .sleep_mode, .osc_stop, .watchdog_clear);
	rsx_prog_model u_rsx_prog_model ();
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	always @(posedge clock) begin
		cyc++;
		if (watchdog_clear === 1'b1) wclr++;
		if (cyc == 20000) begin
			fails++;
			end_of_test();
		end
	end
	task automatic end_of_test();
		$display("comparisons=%0d fails=%0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
			fails++;
		end
	endtask
	// Write: address and data offered together, each released when taken
	task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ta, tw, tk;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(negedge clock);
			ta = s_axi_awvalid & s_axi_awready;
			tw = s_axi_wvalid & s_axi_wready;
			tk = s_axi_bready & s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge clock);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			if (tk) s_axi_bready <= 1'b0;
		end while (!tk);
		@(posedge clock);
	endtask
	task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ta, tk;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(negedge clock);
			ta = s_axi_arvalid & s_axi_arready;
			tk = s_axi_rready & s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge clock);
			if (ta) s_axi_arvalid <= 1'b0;
			if (tk) s_axi_rready <= 1'b0;
		end while (!tk);
		@(posedge clock);
	endtask
	task automatic w(input logic [31:0] a, input logic [31:0] d);
		logic [1:0] r;
		wr(a, d, r);
		chk({30'h0, r}, {30'h0, rsx_pkg::RESP_OKAY});
	endtask
	task automatic rc(input logic [31:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk(d, e);
	endtask
	// Load a program word, start it and poll busy under a bound
	task automatic run(input int i);
		logic [31:0] s;
		logic [1:0] r;
		w(rsx_pkg::ADDR_INSTR, {18'h0, u_rsx_prog_model.word_at(i)});
		w(rsx_pkg::ADDR_STACK, {19'h0, u_rsx_prog_model.ret_at(i)});
		w(rsx_pkg::ADDR_CTRL, 32'h0000_0001);
		s = 32'h0000_0040;
		for (int k = 0; k < 20 && s[6] !== 1'b0; k++) rd(rsx_pkg::ADDR_STATUS, s, r);
		chk({31'h0, s[6]}, 32'h0000_0000);
	endtask
	initial begin
		rst = 1'b1;
		clk_en = 1'b1;
		s_axi_awaddr = 32'h0;
		s_axi_wdata = 32'h0;
		s_axi_araddr = 32'h0;
		s_axi_wstrb = 4'hF;
		s_axi_awvalid = 1'b0;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		rc(rsx_pkg::ADDR_STATUS, 32'h0000_0018);
		rc(rsx_pkg::ADDR_OPTION, 32'h0000_00FF);
		// Literal minus accumulator, negative then zero result
		w(rsx_pkg::ADDR_ACC, 32'h0000_0003);
		run(0);
		rc(rsx_pkg::ADDR_ACC, 32'h0000_00FF);
		rc(rsx_pkg::ADDR_STATUS, 32'h0000_0018);
		w(rsx_pkg::ADDR_ACC, 32'h0000_0002);
		run(0);
		rc(rsx_pkg::ADDR_ACC, 32'h0000_0000);
		rc(rsx_pkg::ADDR_STATUS, 32'h0000_001F);
		// Register minus accumulator back to the register
		w(rsx_pkg::ADDR_FREG, 32'h0000_0003);
		w(rsx_pkg::ADDR_ACC, 32'h0000_0002);
		run(1);
		rc(rsx_pkg::ADDR_FREG, 32'h0000_0001);
		rc(rsx_pkg::ADDR_ACC, 32'h0000_0002);
		rc(rsx_pkg::ADDR_STATUS, 32'h0000_001B);
		// Rotate into accumulator, then back into the register
		w(rsx_pkg::ADDR_FREG, 32'h0000_00E6);
		w(rsx_pkg::ADDR_STATUS, 32'h0000_0000);
		run(2);
		rc(rsx_pkg::ADDR_ACC, 32'h0000_00CC);
		rc(rsx_pkg::ADDR_FREG, 32'h0000_00E6);
		rc(rsx_pkg::ADDR_STATUS, 32'h0000_0019);
		run(9);
		rc(rsx_pkg::ADDR_FREG, 32'h0000_00CD);
		rc(rsx_pkg::ADDR_ACC, 32'h0000_00CC);
		// Nibble swap leaves flags alone
		w(rsx_pkg::ADDR_FREG, 32'h0000_00A5);
		run(3);
		rc(rsx_pkg::ADDR_ACC, 32'h0000_005A);
		rc(rsx_pkg::ADDR_STATUS, 32'h0000_0019);
		// Returns
		w(rsx_pkg::ADDR_IRQCTL, 32'h0000_0000);
		run(4);
		rc(rsx_pkg::ADDR_PC, 32'h0000_0104);
		rc(rsx_pkg::ADDR_IRQCTL, 32'h0000_0080);
		run(5);
		rc(rsx_pkg::ADDR_ACC, 32'h0000_00AB);
		rc(rsx_pkg::ADDR_PC, 32'h0000_0105);
		run(6);
		rc(rsx_pkg::ADDR_PC, 32'h0000_0106);
		rc(rsx_pkg::ADDR_STATUS, 32'h0000_0019);
		// Option load
		w(rsx_pkg::ADDR_ACC, 32'h0000_004F);
		run(7);
		rc(rsx_pkg::ADDR_OPTION, 32'h0000_004F);
		rc(rsx_pkg::ADDR_STATUS, 32'h0000_0019);
		// Sleep, then wake
		wclr = 0;
		run(8);
		chk({30'h0, sleep_mode, osc_stop}, 32'h0000_0003);
		rc(rsx_pkg::ADDR_STATUS, 32'h0000_0031);
		rc(rsx_pkg::ADDR_CTRL, {24'h0, rsx_pkg::WDT_CLEAR});
		chk(32'(wclr), 32'h0000_0001);
		w(rsx_pkg::ADDR_CTRL, 32'h0000_0002);
		chk({31'h0, sleep_mode}, 32'h0000_0000);
		// Unmapped accesses
		rd(32'h0000_0040, v, rs);
		chk(v, 32'h0000_0000);
		chk({30'h0, rs}, {30'h0, rsx_pkg::RESP_SLVERR});
		wr(32'h0000_0040, 32'h0000_0001, rs);
		chk({30'h0, rs}, {30'h0, rsx_pkg::RESP_SLVERR});
		end_of_test();
	end
endmodule
`default_nettype wire
